// >>> hdl/scip_position.sv
// Coarse quadrature count, fine arctangent phase and register slave of the position block
`timescale 1ns/10ps
`default_nettype none
`include "scip_cfg.svh"

module scip_position (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    input  wire logic                          sq_a,
    input  wire logic                          sq_b,
    input  wire logic                          capture_pin,
    input  wire logic signed [`SCIP_ADC_W-1:0] adc_sin,
    input  wire logic signed [`SCIP_ADC_W-1:0] adc_cos,
    input  wire logic                          adc_valid,
    input  wire logic [`SCIP_ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [`SCIP_DATA_W-1:0]       s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [`SCIP_ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [`SCIP_DATA_W-1:0]            s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [`SCIP_CNT_W-1:0]             commutation_position,
    output logic [`SCIP_DATA_W-1:0]            interp_position,
    output logic                               compare_match,
    output logic                               capture_flag
);

    localparam scip_pkg::scip_pos_regs_t RST = '{decode: `SCIP_DEC_RESET, default: '0};

    scip_pkg::scip_pos_regs_t r;
    scip_pkg::scip_pos_regs_t next_r;

    logic [`SCIP_PHASE_W-1:0] cord_phase;
    logic                     cord_done;
    logic                     aw_take;
    logic                     w_take;
    logic                     ar_take;

    // Byte-lane merge for writable registers
    function automatic logic [`SCIP_DATA_W-1:0] merge(
        input logic [`SCIP_DATA_W-1:0] old_word,
        input logic [`SCIP_DATA_W-1:0] new_word,
        input logic [3:0]              strb
    );
        logic [`SCIP_DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Whether a channel transition yields a count in the given decode mode
    function automatic logic count_enable(
        input logic [1:0] mode,
        input logic       edge_a,
        input logic       edge_b,
        input logic       level_a
    );
        logic en;
        en = 1'b0;
        if (edge_a && edge_b) begin
            en = 1'b0;
        end else begin
            unique case (mode)
                `SCIP_DEC_X4: en = edge_a | edge_b;
                `SCIP_DEC_X2: en = edge_a;
                `SCIP_DEC_X1: en = edge_a & level_a;
                default:      en = 1'b0;
            endcase
        end
        return en;
    endfunction

    // Fine phase from the arctangent of each sample pair that arrives while the arctangent is idle
    scip_arctan u_arctan (
        .clk    (clk),
        .nrst   (nrst),
        .ce     (ce),
        .start  (adc_valid),
        .sin_in (adc_sin),
        .cos_in (adc_cos),
        .phase  (cord_phase),
        .done   (cord_done)
    );

    // Handshakes; ready drops while frozen so nothing is taken unseen
    assign s_axi_awready = ce & ~r.aw_got & ~r.bvalid;
    assign s_axi_wready  = ce & ~r.w_got & ~r.bvalid;
    assign s_axi_arready = ce & ~r.rvalid;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign ar_take       = s_axi_arvalid & s_axi_arready;

    // Next-state logic for the counter, phase, compare, capture and bus
    always_comb begin
        logic                     edge_a;
        logic                     edge_b;
        logic                     up;
        logic [`SCIP_PHASE_W-1:0] phase_dir;
        logic [`SCIP_PHASE_W-1:0] delta;
        logic                     wr_now;
        logic                     clr_capt;
        edge_a    = 1'b0;
        edge_b    = 1'b0;
        up        = 1'b0;
        phase_dir = '0;
        delta     = '0;
        wr_now    = 1'b0;
        clr_capt  = 1'b0;
        next_r    = r;

        // Two-stage synchronisers, then a third stage for edge detection
        next_r.a_m = sq_a;
        next_r.a_s = r.a_m;
        next_r.a_p = r.a_s;
        next_r.b_m = sq_b;
        next_r.b_s = r.b_m;
        next_r.b_p = r.b_s;
        next_r.t_m = capture_pin;
        next_r.t_s = r.t_m;
        next_r.t_p = r.t_s;

        // Quadrature up/down count; direction bit clear reverses it
        edge_a = r.a_s ^ r.a_p;
        edge_b = r.b_s ^ r.b_p;
        up     = (r.a_s ^ r.b_p) ~^ r.decode[`SCIP_DEC_DIR];
        if (count_enable(r.decode[1:0], edge_a, edge_b, r.a_s)) begin
            if (up) begin
                next_r.count = r.count + `SCIP_CNT_W'(1);
            end else begin
                next_r.count = r.count - `SCIP_CNT_W'(1);
            end
        end

        // Compare and capture both work in hardware counts
        next_r.match = (r.count == r.compare);
        if (r.t_s && !r.t_p) begin
            next_r.capture = r.count;
        end

        // Latest line phase, mirrored when the count runs reversed
        if (cord_done) begin
            next_r.phase       = cord_phase;
            next_r.phase_valid = 1'b1;
        end
        if (r.decode[`SCIP_DEC_DIR]) begin
            phase_dir = r.phase;
        end else begin
            phase_dir = -r.phase;
        end

        // Phase taken relative to the counter's quarter so the word is seamless
        delta = phase_dir - {r.count[1:0], `SCIP_FINE_W'(0)};
        next_r.interp = {r.count[`SCIP_DATA_W-`SCIP_FINE_W-1:0], `SCIP_FINE_W'(0)}
                      + `SCIP_DATA_W'(signed'(delta));

        // Write channel: address and data may arrive in either order
        if (aw_take) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            next_r.w_got  = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        wr_now = r.aw_got & r.w_got;
        if (wr_now) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = `SCIP_RESP_OKAY;
            unique case (r.aw_addr)
                `SCIP_REG_CTRL: begin
                    next_r.decode = `SCIP_DEC_W'(merge({29'h0, r.decode}, r.w_data,
                                                       r.w_strb));
                end
                `SCIP_REG_CMP: begin
                    next_r.compare = `SCIP_CNT_W'(merge({8'h00, r.compare}, r.w_data,
                                                        r.w_strb));
                end
                `SCIP_REG_STAT: begin
                    clr_capt = r.w_strb[0] & r.w_data[`SCIP_STAT_CAPT];
                end
                `SCIP_REG_COUNT, `SCIP_REG_INTERP, `SCIP_REG_PHASE, `SCIP_REG_CAPT: begin
                    // Read-only words accept and ignore the write
                    next_r.bresp = `SCIP_RESP_OKAY;
                end
                default: begin
                    next_r.bresp = `SCIP_RESP_SLVERR;
                end
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // Capture flag: a new capture in the clearing cycle wins
        if (clr_capt) begin
            next_r.capt_flag = 1'b0;
        end
        if (r.t_s && !r.t_p) begin
            next_r.capt_flag = 1'b1;
        end

        // Read channel: one cycle from address to data
        if (ar_take) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = `SCIP_RESP_OKAY;
            unique case (s_axi_araddr)
                `SCIP_REG_CTRL:   next_r.rdata = {29'h0, r.decode};
                `SCIP_REG_COUNT:  next_r.rdata = {8'h00, r.count};
                `SCIP_REG_INTERP: next_r.rdata = r.interp;
                `SCIP_REG_PHASE:  next_r.rdata = {20'h0, r.phase};
                `SCIP_REG_CMP:    next_r.rdata = {8'h00, r.compare};
                `SCIP_REG_CAPT:   next_r.rdata = {8'h00, r.capture};
                `SCIP_REG_STAT:   next_r.rdata = {29'h0, r.phase_valid, r.match, r.capt_flag};
                default: begin
                    next_r.rdata = '0;
                    next_r.rresp = `SCIP_RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    // All state in one register; low clock enable holds everything
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Bus answers from flip-flops
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp  = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp  = r.rresp;
    assign s_axi_rdata  = r.rdata;

    // Commutation uses only the coarse count; the fine word is for servo use
    assign commutation_position = r.count;
    assign interp_position      = r.interp;
    assign compare_match        = r.match;
    assign capture_flag         = r.capt_flag;

endmodule // scip_position

`default_nettype wire

// >>> hdl/scip_cfg.svh
// Constants for the sine/cosine interpolated position block
`ifndef SCIP_CFG_SVH
`define SCIP_CFG_SVH

// Widths
`define SCIP_DATA_W      32
`define SCIP_ADDR_W      8
`define SCIP_CNT_W       24
`define SCIP_ADC_W       12
`define SCIP_PHASE_W     12
`define SCIP_FINE_W      10
`define SCIP_CORDIC_W    15
`define SCIP_DEC_W       3

// Arctangent stage
`define SCIP_CORDIC_LAST 4'ha
`define SCIP_HALF_TURN   12'h800

// Decode setting: low two bits select the multiply, bit 2 the direction
`define SCIP_DEC_RESET   3'h7
`define SCIP_DEC_DIR     2
`define SCIP_DEC_X4      2'h3
`define SCIP_DEC_X2      2'h2
`define SCIP_DEC_X1      2'h1

// Register byte addresses
`define SCIP_REG_CTRL    8'h00
`define SCIP_REG_COUNT   8'h04
`define SCIP_REG_INTERP  8'h08
`define SCIP_REG_PHASE   8'h0c
`define SCIP_REG_CMP     8'h10
`define SCIP_REG_CAPT    8'h14
`define SCIP_REG_STAT    8'h18

// Status bit positions
`define SCIP_STAT_CAPT   0
`define SCIP_STAT_MATCH  1
`define SCIP_STAT_PVALID 2

// Bus responses
`define SCIP_RESP_OKAY   2'h0
`define SCIP_RESP_SLVERR 2'h2

`endif

// >>> hdl/scip_pkg.sv
// Types shared by the interpolated position block
`include "scip_cfg.svh"

package scip_pkg;

    typedef enum logic [1:0] {
        SCIP_CORD_IDLE = 2'b01,
        SCIP_CORD_RUN  = 2'b10
    } scip_cord_state_t;

    typedef struct packed {
        scip_cord_state_t                   state;
        logic [3:0]                         iter;
        logic signed [`SCIP_CORDIC_W-1:0]   x;
        logic signed [`SCIP_CORDIC_W-1:0]   y;
        logic [`SCIP_PHASE_W-1:0]           z;
        logic [`SCIP_PHASE_W-1:0]           phase;
        logic                               done;
    } scip_cord_regs_t;

    typedef struct packed {
        logic                       a_m;
        logic                       a_s;
        logic                       a_p;
        logic                       b_m;
        logic                       b_s;
        logic                       b_p;
        logic                       t_m;
        logic                       t_s;
        logic                       t_p;
        logic [`SCIP_DEC_W-1:0]     decode;
        logic [`SCIP_CNT_W-1:0]     count;
        logic [`SCIP_CNT_W-1:0]     compare;
        logic [`SCIP_CNT_W-1:0]     capture;
        logic                       capt_flag;
        logic                       match;
        logic                       phase_valid;
        logic [`SCIP_PHASE_W-1:0]   phase;
        logic [`SCIP_DATA_W-1:0]    interp;
        logic                       aw_got;
        logic                       w_got;
        logic [`SCIP_ADDR_W-1:0]    aw_addr;
        logic [`SCIP_DATA_W-1:0]    w_data;
        logic [3:0]                 w_strb;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [`SCIP_DATA_W-1:0]    rdata;
    } scip_pos_regs_t;

endpackage

// >>> hdl/scip_arctan.sv
// Iterative arctangent of a sine/cosine sample pair to a 12-bit line phase
`timescale 1ns/10ps
`default_nettype none
`include "scip_cfg.svh"

module scip_arctan (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    input  wire logic                          start,
    input  wire logic signed [`SCIP_ADC_W-1:0] sin_in,
    input  wire logic signed [`SCIP_ADC_W-1:0] cos_in,
    output logic [`SCIP_PHASE_W-1:0]           phase,
    output logic                               done
);

    localparam scip_pkg::scip_cord_regs_t RST = '{state: scip_pkg::SCIP_CORD_IDLE, default: '0};

    scip_pkg::scip_cord_regs_t r;
    scip_pkg::scip_cord_regs_t next_r;

    // Angle of atan(2^-i) in 1/4096 turn
    function automatic logic [`SCIP_PHASE_W-1:0] atan_step(input logic [3:0] i);
        unique case (i)
            4'h0:    atan_step = 12'h200;
            4'h1:    atan_step = 12'h12e;
            4'h2:    atan_step = 12'h0a0;
            4'h3:    atan_step = 12'h051;
            4'h4:    atan_step = 12'h029;
            4'h5:    atan_step = 12'h014;
            4'h6:    atan_step = 12'h00a;
            4'h7:    atan_step = 12'h005;
            4'h8:    atan_step = 12'h003;
            default: atan_step = 12'h001;
        endcase
    endfunction

    // One micro-rotation per cycle; a sample offered while busy is dropped
    always_comb begin
        logic signed [`SCIP_CORDIC_W-1:0] xs;
        logic signed [`SCIP_CORDIC_W-1:0] ys;
        xs = r.x >>> r.iter;
        ys = r.y >>> r.iter;
        next_r = r;
        next_r.done = 1'b0;
        unique case (r.state)
            scip_pkg::SCIP_CORD_IDLE: begin
                if (start) begin
                    // Fold the left half plane over so the rotation converges
                    next_r.state = scip_pkg::SCIP_CORD_RUN;
                    next_r.iter  = 4'h0;
                    if (cos_in[`SCIP_ADC_W-1]) begin
                        next_r.x = -`SCIP_CORDIC_W'(cos_in);
                        next_r.y = -`SCIP_CORDIC_W'(sin_in);
                        next_r.z = `SCIP_HALF_TURN;
                    end else begin
                        next_r.x = `SCIP_CORDIC_W'(cos_in);
                        next_r.y = `SCIP_CORDIC_W'(sin_in);
                        next_r.z = '0;
                    end
                end
            end
            scip_pkg::SCIP_CORD_RUN: begin
                if (r.y[`SCIP_CORDIC_W-1]) begin
                    next_r.x = r.x - ys;
                    next_r.y = r.y + xs;
                    next_r.z = r.z - atan_step(r.iter);
                end else begin
                    next_r.x = r.x + ys;
                    next_r.y = r.y - xs;
                    next_r.z = r.z + atan_step(r.iter);
                end
                next_r.iter = r.iter + 4'h1;
                if (r.iter == `SCIP_CORDIC_LAST) begin
                    next_r.state = scip_pkg::SCIP_CORD_IDLE;
                    next_r.phase = next_r.z;
                    next_r.done  = 1'b1;
                end
            end
        endcase
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign phase = r.phase;
    assign done  = r.done & ce;

endmodule // scip_arctan

`default_nettype wire

// >>> test/scip_pos_properties.sv
// Port checker of the interpolated position block
`timescale 1ns/10ps
`default_nettype none
`include "scip_cfg.svh"

module scip_pos_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        sq_a,
    input wire logic        sq_b,
    input wire logic        capture_pin,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [23:0] commutation_position,
    input wire logic [31:0] interp_position,
    input wire logic        compare_match,
    input wire logic        capture_flag
);
    logic [21:0] hi_diff;

    // Whole-count part of the fine word, relative to the counter
    assign hi_diff = interp_position[31:10] - commutation_position[21:0];

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_reset_clear: assert property (disable iff (1'b0)
        (!nrst && ce) |=> (commutation_position == 24'h0 && !capture_flag))
        else $error("count or flag not cleared by reset");
    a_count_step: assert property (
        ($past(nrst) && $changed(commutation_position)) |->
        (commutation_position - $past(commutation_position)) inside {24'h1, 24'hffffff})
        else $error("count moved by more than one");
    a_count_quiet: assert property (
        (ce && $stable(sq_a) && $stable(sq_b))[*7] |=> $stable(commutation_position))
        else $error("count moved without a pin edge");
    a_capt_cause: assert property (
        $rose(capture_flag) |->
        ($past(capture_pin, 3) || $past(capture_pin, 4) || $past(capture_pin, 5)))
        else $error("capture flag without trigger");
    a_capt_timely: assert property (
        (ce && $rose(capture_pin)) |-> ##[1:6] capture_flag)
        else $error("capture flag late");
    // Two matches in a row only while the counter stood still
    a_match_hold: assert property (
        (compare_match && $past(compare_match)) |->
        $past(commutation_position) == $past(commutation_position, 2))
        else $error("match held while count moved");
    a_interp_align: assert property (
        ($stable(commutation_position))[*3] |->
        hi_diff inside {22'h0, 22'h1, 22'h3ffffe, 22'h3fffff})
        else $error("fine word off the counter");
    a_freeze_hold: assert property (
        !ce |=> ($stable(commutation_position) && $stable(capture_flag)))
        else $error("state moved while frozen");
    a_read_answer: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read answer late");
    a_resp_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write answer dropped");
endmodule // scip_pos_checker

bind scip_position scip_pos_checker i_chk (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .sq_a(sq_a),
    .sq_b(sq_b),
    .capture_pin(capture_pin),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .commutation_position(commutation_position),
    .interp_position(interp_position),
    .compare_match(compare_match),
    .capture_flag(capture_flag)
);
`default_nettype wire

// >>> test/scip_encoder_model.sv
// Sine/cosine encoder model: squared channels and ADC samples
`timescale 1ns/10ps
`default_nettype none

module scip_encoder_model (
    input  wire logic          clk,
    input  wire logic          step,
    input  wire logic          step_up,
    output logic               sq_a,
    output logic               sq_b,
    output logic signed [11:0] adc_sin,
    output logic signed [11:0] adc_cos,
    output logic               adc_valid
);
    logic [1:0] q = 2'h0;

    // Quarter-line position, one step per request; sample follows the move
    always @(posedge clk) begin
        if (step) begin
            q <= step_up ? q + 2'h1 : q - 2'h1;
        end
        adc_valid <= step;
    end

    // Gray code, A leads B when moving up
    assign sq_a = q[0] ^ q[1];
    assign sq_b = q[1];
    // Mid-quarter samples so the angle is never on a boundary
    assign adc_sin = q[1] ? 12'hc18 : 12'h3e8;
    assign adc_cos = (q[0] ^ q[1]) ? 12'hc18 : 12'h3e8;
endmodule // scip_encoder_model
`default_nettype wire

// >>> test/scip_position_bench.sv
// Self-checking bench of the interpolated position block
`timescale 1ns/10ps
`default_nettype none
`include "scip_cfg.svh"

module scip_position_bench;
    typedef struct packed {
        logic        up;
        logic [23:0] cnt;
    } scip_row_t;

    logic               clk, nrst, ce, capture_pin, enc_step, enc_up;
    logic               sq_a, sq_b, adc_valid;
    logic signed [11:0] adc_sin, adc_cos;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata, rd, interp_position;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready, compare_match, capture_flag;
    logic [1:0]         bresp, rresp, resp;
    logic [23:0]        commutation_position;
    int                 errors, n_checks;
    // Step direction beside the count it should give
    scip_row_t rows [12] = '{'{1'b1, 24'h1}, '{1'b1, 24'h2}, '{1'b1, 24'h3},
        '{1'b1, 24'h4}, '{1'b1, 24'h5}, '{1'b0, 24'h4}, '{1'b0, 24'h3}, '{1'b0, 24'h2},
        '{1'b0, 24'h1}, '{1'b0, 24'h0}, '{1'b0, 24'hffffff}, '{1'b0, 24'hfffffe}};

    scip_encoder_model i_enc (.clk(clk), .step(enc_step), .step_up(enc_up), .sq_a(sq_a),
        .sq_b(sq_b), .adc_sin(adc_sin), .adc_cos(adc_cos), .adc_valid(adc_valid));

    scip_position i_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .sq_a(sq_a), .sq_b(sq_b),
        .capture_pin(capture_pin), .adc_sin(adc_sin), .adc_cos(adc_cos),
        .adc_valid(adc_valid), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .commutation_position(commutation_position), .interp_position(interp_position),
        .compare_match(compare_match), .capture_flag(capture_flag));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Arctangent rounding allows a few states either way
    task automatic near(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if ($isunknown(got) || ((got - exp + 32'h4) > 32'h8)) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        r = bresp;
        bready <= 1'b0;
        if (n >= 200) errors++;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 200) errors++;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
        rd_reg(a, rd, resp);
        chk(name, exp, rd);
        chk("read response", {30'h0, `SCIP_RESP_OKAY}, {30'h0, resp});
    endtask

    // One quarter-line move, then time for sync, count and arctangent
    task automatic step(input logic up);
        @(posedge clk);
        enc_step <= 1'b1;
        enc_up <= up;
        @(posedge clk);
        enc_step <= 1'b0;
        repeat (24) @(posedge clk);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (6000) @(posedge clk);
        errors++;
        test_done;
    end

    initial begin
        {nrst, capture_pin, enc_step, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        ce = 1'b1;
        enc_up = 1'b1;
        errors = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        chk("reset count", 32'h0, {8'h0, commutation_position});
        chk_reg(`SCIP_REG_CTRL, 32'h7, "decode");
        chk_reg(`SCIP_REG_CMP, 32'h0, "compare");
        chk_reg(`SCIP_REG_STAT, 32'h2, "status");
        foreach (rows[i]) begin
            step(rows[i].up);
            chk("commutation", {8'h0, rows[i].cnt}, {8'h0, commutation_position});
            chk_reg(`SCIP_REG_COUNT, {8'h0, rows[i].cnt}, "count");
            near("interp", {rows[i].cnt[21:0], 10'h200}, interp_position);
            rd_reg(`SCIP_REG_PHASE, rd, resp);
            near("phase", {20'h0, rows[i].cnt[1:0], 10'h200}, rd);
        end
        // Capture of a negative count
        capture_pin <= 1'b1;
        repeat (3) @(posedge clk);
        capture_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk("capture flag", 32'h1, {31'h0, capture_flag});
        chk_reg(`SCIP_REG_CAPT, 32'h00fffffe, "capture");
        chk_reg(`SCIP_REG_STAT, 32'h5, "status");
        wr(`SCIP_REG_STAT, 32'h1, resp);
        chk_reg(`SCIP_REG_STAT, 32'h4, "status cleared");
        // Compare against the next hardware count
        wr(`SCIP_REG_CMP, 32'h00ffffff, resp);
        chk("match early", 32'h0, {31'h0, compare_match});
        step(1'b1);
        chk("match", 32'h1, {31'h0, compare_match});
        chk_reg(`SCIP_REG_STAT, 32'h6, "status match");
        step(1'b1);
        chk("match gone", 32'h0, {31'h0, compare_match});
        // Other times-4 value turns the count round
        wr(`SCIP_REG_CTRL, 32'h3, resp);
        chk_reg(`SCIP_REG_CTRL, 32'h3, "decode");
        step(1'b1);
        chk("reversed", 32'h00ffffff, {8'h0, commutation_position});
        // Read-only and unmapped words
        wr(`SCIP_REG_COUNT, 32'h123, resp);
        chk("ro write", {30'h0, `SCIP_RESP_OKAY}, {30'h0, resp});
        chk("count kept", 32'h00ffffff, {8'h0, commutation_position});
        wr(8'h1c, 32'h1, resp);
        chk("unmapped write", {30'h0, `SCIP_RESP_SLVERR}, {30'h0, resp});
        rd_reg(8'h1c, rd, resp);
        chk("unmapped read", {30'h0, `SCIP_RESP_SLVERR}, {30'h0, resp});
        chk("unmapped data", 32'h0, rd);
        // Second reset in mid-run restores the default decode
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset count", 32'h0, {8'h0, commutation_position});
        nrst <= 1'b1;
        chk_reg(`SCIP_REG_CTRL, 32'h7, "decode");
        test_done;
    end
endmodule // scip_position_bench
`default_nettype wire
